/* rtl/rlmt_pkg.sv */
// Package of constants and types for the retry limit and master timeout block
package rlmt_pkg;
  // Register byte offsets
  localparam logic [7:0] RLMT_CTRL_OFF = 8'h00;
  localparam logic [7:0] RLMT_BASE_OFF = 8'h04;
  localparam logic [7:0] RLMT_STAT_OFF = 8'h08;
  localparam logic [7:0] RLMT_MASK_OFF = 8'h0c;
  // Control field positions
  localparam int RLMT_RETRY_LSB = 0;
  localparam int RLMT_PDIV_LSB = 4;
  localparam int RLMT_SDIV_LSB = 6;
  localparam logic [7:0] RLMT_CTRL_RST = 8'h00;
  localparam logic [7:0] RLMT_CTRL_WMASK = 8'hf7;
  // Base/enable register: bit0 primary short base, bit1 secondary short base,
  // bit2 primary error enable, bit3 secondary error enable
  localparam logic [3:0] RLMT_BASE_RST = 4'h0;
  // Status bits
  localparam int RLMT_ST_PRTY = 0;
  localparam int RLMT_ST_SRTY = 1;
  localparam int RLMT_ST_PMTO = 2;
  localparam int RLMT_ST_SMTO = 3;
  // Base master timeout in clocks
  localparam logic [15:0] RLMT_BASE_LONG = 16'h8000;
  localparam logic [15:0] RLMT_BASE_SHORT = 16'h0400;
  localparam logic [24:0] RLMT_RETRY_MAX = 25'h1000000;

  typedef struct packed {
    logic start;
    logic retry;
    logic done;
  } rlmt_port_ev_type;

  // Retry limit decode; unlisted codes give the smallest limit of one
  function automatic logic [24:0] rlmt_retry_limit(input logic [2:0] code);
    case (code)
      3'h0: rlmt_retry_limit = RLMT_RETRY_MAX;
      3'h1: rlmt_retry_limit = 25'h0040000;
      3'h2: rlmt_retry_limit = 25'h0001000;
      3'h3: rlmt_retry_limit = 25'h0000040;
      default: rlmt_retry_limit = 25'h0000001;
    endcase
  endfunction

  // Master timeout after the two-bit divider
  function automatic logic [15:0] rlmt_mto_count(input logic [1:0] div, input logic short_base);
    logic [15:0] base;
    base = short_base ? RLMT_BASE_SHORT : RLMT_BASE_LONG;
    case (div)
      2'h3: rlmt_mto_count = base >> 8;
      2'h2: rlmt_mto_count = base >> 4;
      2'h1: rlmt_mto_count = base >> 3;
      default: rlmt_mto_count = base;
    endcase
  endfunction
endpackage

/* rtl/rlmt_port.sv */
// Per-port retry counter and master timeout counter
`timescale 1ns/100ps
module rlmt_port
  import rlmt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire rlmt_port_ev_type ev,
  input wire logic master_busy,
  input wire logic [2:0] retry_code,
  input wire logic [1:0] div_code,
  input wire logic short_base,
  output logic retry_to,
  output logic mto
);
  logic [24:0] rcnt_reg, rcnt_next;
  logic [15:0] mcnt_reg, mcnt_next;
  logic retry_to_reg, retry_to_next, mto_reg, mto_next;
  logic [24:0] lim;
  logic [15:0] mlim;

  always_comb begin
    lim = rlmt_retry_limit(retry_code);
    mlim = rlmt_mto_count(div_code, short_base);
    rcnt_next = rcnt_reg;
    retry_to_next = 1'b0;
    if (ev.start || ev.done) begin
      rcnt_next = '0;
    end else if (ev.retry) begin
      if (rcnt_reg + 25'h1 >= lim) begin
        retry_to_next = 1'b1;
        rcnt_next = '0;
      end else begin
        rcnt_next = rcnt_reg + 25'h1;
      end
    end
    mcnt_next = '0;
    mto_next = 1'b0;
    if (master_busy) begin
      if (mcnt_reg + 16'h1 >= mlim) begin
        mto_next = (mcnt_reg + 16'h1 == mlim);
        mcnt_next = mcnt_reg;
        if (mto_next) begin
          mcnt_next = mcnt_reg + 16'h1;
        end
      end else begin
        mcnt_next = mcnt_reg + 16'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rcnt_reg <= '0;
      mcnt_reg <= '0;
      retry_to_reg <= 1'b0;
      mto_reg <= 1'b0;
    end else begin
      rcnt_reg <= rcnt_next;
      mcnt_reg <= mcnt_next;
      retry_to_reg <= retry_to_next;
      mto_reg <= mto_next;
    end
  end

  assign retry_to = retry_to_reg;
  assign mto = mto_reg;

  rtry_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
    rcnt_reg < lim || rcnt_reg == $past(rcnt_reg)) else $error("retry count passed limit");
  rtry_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    (retry_code == 3'h7 && $stable(retry_code) && ev.retry && !ev.start && !ev.done) |=> retry_to)
    else $error("limit one did not time out");
  rtry_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    retry_to |=> !retry_to) else $error("retry timeout not a pulse");
  mto_div_a: assert property (@(posedge pclk) disable iff (!presetn)
    (div_code == 2'h3 && !short_base && master_busy && mcnt_reg == 16'h007f) |=> mto)
    else $error("divide by 256 timeout wrong");
  mto_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !master_busy |=> (mcnt_reg == 16'h0 && !mto)) else $error("master counter not cleared");
endmodule

/* rtl/rlmt_top.sv */
// Retry limit and master timeout divider block with APB registers
`timescale 1ns/100ps
module rlmt_top
  import rlmt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rlmt_port_ev_type pri_ev,
  input wire rlmt_port_ev_type sec_ev,
  input wire logic pri_master_busy,
  input wire logic sec_master_busy,
  output logic pri_serr,
  output logic sec_serr,
  output logic irq
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl_reg, ctrl_next;
  logic [3:0] base_reg, base_next;
  logic [3:0] stat_reg, stat_next;
  logic [3:0] mask_reg, mask_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pslverr_reg, pslverr_next;
  logic pready_reg, pready_next;
  logic pri_serr_reg, pri_serr_next, sec_serr_reg, sec_serr_next, irq_reg, irq_next;
  logic p_rto, s_rto, p_mto, s_mto;
  logic wr, rd, hit;
  logic [3:0] ev;

  // Answer in the first access cycle; pready is registered from setup
  always_comb begin
    wr = psel && penable && pready_reg && pwrite;
    rd = psel && !penable && !pwrite;
    hit = (paddr == RLMT_CTRL_OFF) || (paddr == RLMT_BASE_OFF) ||
          (paddr == RLMT_STAT_OFF) || (paddr == RLMT_MASK_OFF);
    pready_next = psel && !penable;
    pslverr_next = psel && !penable && !hit ? 1'b1 : (psel && penable ? pslverr_reg : 1'b0);
    prdata_next = psel && penable ? prdata_reg : 32'h0;
    if (rd) begin
      case (paddr)
        RLMT_CTRL_OFF: prdata_next = {24'h0, ctrl_reg};
        RLMT_BASE_OFF: prdata_next = {28'h0, base_reg};
        RLMT_STAT_OFF: prdata_next = {28'h0, stat_reg};
        RLMT_MASK_OFF: prdata_next = {28'h0, mask_reg};
        default: prdata_next = 32'h0;
      endcase
    end
    ev = {s_mto, p_mto, s_rto, p_rto};
    ctrl_next = ctrl_reg;
    base_next = base_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    if (wr && paddr == RLMT_CTRL_OFF) begin
      ctrl_next = pwdata[7:0] & RLMT_CTRL_WMASK;
    end
    if (wr && paddr == RLMT_BASE_OFF) begin
      base_next = pwdata[3:0];
    end
    if (wr && paddr == RLMT_MASK_OFF) begin
      mask_next = pwdata[3:0];
    end
    if (wr && paddr == RLMT_STAT_OFF) begin
      stat_next = stat_reg & ~pwdata[3:0];
    end
    // Set wins over a clear in the same cycle
    stat_next = stat_next | ev;
    pri_serr_next = p_rto && base_reg[2];
    sec_serr_next = s_rto && base_reg[3];
    irq_next = |(stat_next & mask_next);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= RLMT_CTRL_RST;
      base_reg <= RLMT_BASE_RST;
      stat_reg <= 4'h0;
      mask_reg <= 4'h0;
      prdata_reg <= 32'h0;
      pslverr_reg <= 1'b0;
      pready_reg <= 1'b0;
      pri_serr_reg <= 1'b0;
      sec_serr_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      base_reg <= base_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
      pready_reg <= pready_next;
      pri_serr_reg <= pri_serr_next;
      sec_serr_reg <= sec_serr_next;
      irq_reg <= irq_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pri_serr = pri_serr_reg;
  assign sec_serr = sec_serr_reg;
  assign irq = irq_reg;

  // ----------------------------------------------------------------
  // Port counters
  // ----------------------------------------------------------------
  rlmt_port u_pri (
    .pclk(pclk),
    .presetn(presetn),
    .ev(pri_ev),
    .master_busy(pri_master_busy),
    .retry_code(ctrl_reg[RLMT_RETRY_LSB +: 3]),
    .div_code(ctrl_reg[RLMT_PDIV_LSB +: 2]),
    .short_base(base_reg[0]),
    .retry_to(p_rto),
    .mto(p_mto)
  );

  rlmt_port u_sec (
    .pclk(pclk),
    .presetn(presetn),
    .ev(sec_ev),
    .master_busy(sec_master_busy),
    .retry_code(ctrl_reg[RLMT_RETRY_LSB +: 3]),
    .div_code(ctrl_reg[RLMT_SDIV_LSB +: 2]),
    .short_base(base_reg[1]),
    .retry_to(s_rto),
    .mto(s_mto)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence apb_setup_s;
    psel && !penable;
  endsequence
  apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    apb_setup_s |=> pready) else $error("no ready after setup");
  ctrl_rsv_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[3] == 1'b0) else $error("reserved control bit set");
  serr_pri_a: assert property (@(posedge pclk) disable iff (!presetn)
    (p_rto && base_reg[2]) |=> pri_serr) else $error("primary serr missing");
  serr_sec_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_rto && !base_reg[3]) |=> !sec_serr) else $error("secondary serr not gated");
  stat_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    p_rto |=> stat_reg[RLMT_ST_PRTY]) else $error("status not set");
  irq_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(stat_reg & mask_reg)) else $error("irq does not follow masked status");
endmodule

/* bench/rlmt_pci_agent.sv */
// Model of the initiators and targets on one side of the bridge
`timescale 1ns/100ps
module rlmt_pci_agent
  import rlmt_pkg::*;
(
  input wire logic pclk,
  output rlmt_port_ev_type ev,
  output logic busy
);
  initial begin
    ev = '0;
    busy = 1'b0;
  end

  // One forwarded cycle, retried n times by the target; gap idles make a slow target
  task automatic forward(input int n, input int gap);
    @(posedge pclk);
    ev <= '{1'b1, 1'b0, 1'b0};
    repeat (n) begin
      @(posedge pclk);
      ev <= '{1'b0, 1'b1, 1'b0};
      @(posedge pclk);
      ev <= '0;
      repeat (gap) @(posedge pclk);
    end
    @(posedge pclk);
    ev <= '{1'b0, 1'b0, 1'b1};
    @(posedge pclk);
    ev <= '0;
  endtask

  // Nobody claims the access for n cycles
  task automatic decode_wait(input int n);
    @(posedge pclk);
    busy <= 1'b1;
    repeat (n) @(posedge pclk);
    busy <= 1'b0;
  endtask
endmodule

/* bench/rlmt_top_test.sv */
// Self-checking bench for the retry limit and master timeout block
`timescale 1ns/100ps
module rlmt_top_test
  import rlmt_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, pri_serr, sec_serr, irq, pbusy, sbusy, last_err;
  logic serr_on = 1'b1;
  rlmt_port_ev_type pev, sev;
  int failures = 0;
  int samples_checked = 0;
  int serr_cnt[2] = '{0, 0};
  int shamt[4] = '{0, 3, 4, 8};

  always #5 pclk = ~pclk;

  always @(posedge pclk) begin
    if (pri_serr === 1'b1) serr_cnt[0]++;
    if (sec_serr === 1'b1) serr_cnt[1]++;
  end

  rlmt_top i_rlmt_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pri_ev(pev),
    .sec_ev(sev), .pri_master_busy(pbusy), .sec_master_busy(sbusy), .pri_serr(pri_serr),
    .sec_serr(sec_serr), .irq(irq));
  rlmt_pci_agent i_pri_agent (.pclk(pclk), .ev(pev), .busy(pbusy));
  rlmt_pci_agent i_sec_agent (.pclk(pclk), .ev(sev), .busy(sbusy));

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Starts one edge after entry so a release and a new setup never share a time step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait count assumed; only the watchdog ends a hang
    do @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic retry_case(input int p, input logic [2:0] code, input int n, input int gap, input int reps,
                            input logic e);
    int s0;
    apb(1'b1, RLMT_CTRL_OFF, {29'h0, code});
    s0 = serr_cnt[p];
    repeat (reps) begin
      if (p == 0) i_pri_agent.forward(n, gap);
      else i_sec_agent.forward(n, gap);
    end
    repeat (4) @(posedge pclk);
    apb(1'b0, RLMT_STAT_OFF, 32'h0);
    chk("retry status", q, 32'(e) << p);
    chk("serr pulses", 32'(serr_cnt[p] - s0), 32'(e & serr_on));
    chk("irq raised", {31'h0, irq}, 32'(e && p == 0));
    apb(1'b1, RLMT_STAT_OFF, 32'hf);
    repeat (3) @(posedge pclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    $display("retry test code %0d count %0d done", code, n);
  endtask

  task automatic mto_case(input int p, input logic sh, input logic [1:0] dv, input int extra, input logic e);
    int lim;
    lim = (sh ? 1024 : 32768) >> shamt[dv];
    apb(1'b1, RLMT_BASE_OFF, {28'h0, 2'b11, sh, sh});
    apb(1'b1, RLMT_CTRL_OFF, {24'h0, dv, dv, 4'h3});
    if (p == 0) i_pri_agent.decode_wait(lim + extra);
    else i_sec_agent.decode_wait(lim + extra);
    repeat (3) @(posedge pclk);
    apb(1'b0, RLMT_STAT_OFF, 32'h0);
    chk("timeout status", q, 32'(e) << (p + 2));
    apb(1'b1, RLMT_STAT_OFF, 32'hf);
    $display("timeout test port %0d div %0d done", p, dv);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, RLMT_CTRL_OFF, 32'h0);
    chk("ctrl reset", q, 32'h0);
    apb(1'b1, RLMT_CTRL_OFF, 32'hff);
    apb(1'b0, RLMT_CTRL_OFF, 32'h0);
    chk("ctrl fields", q, 32'hf7);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", {q[31:1], last_err}, 32'h1);
    $display("register test done");
    apb(1'b1, RLMT_BASE_OFF, 32'hc);
    apb(1'b1, RLMT_MASK_OFF, 32'h5);
    apb(1'b0, RLMT_BASE_OFF, 32'h0);
    chk("base readback", q, 32'hc);
    apb(1'b0, RLMT_MASK_OFF, 32'h0);
    chk("mask readback", q, 32'h5);
    retry_case(0, 3'h3, 63, 0, 1, 1'b0);
    retry_case(0, 3'h3, 64, 2, 1, 1'b1);
    retry_case(1, 3'h3, 64, 0, 1, 1'b1);
    retry_case(0, 3'h3, 40, 1, 2, 1'b0);
    retry_case(1, 3'h2, 4096, 0, 1, 1'b1);
    retry_case(0, 3'h0, 200, 0, 1, 1'b0);
    retry_case(1, 3'h1, 200, 0, 1, 1'b0);
    for (int c = 4; c < 8; c++) retry_case(c % 2, 3'(c), 1, 0, 1, 1'b1);
    // Error enables off: status still set, no SERR pulse
    serr_on = 1'b0;
    apb(1'b1, RLMT_BASE_OFF, 32'h0);
    retry_case(1, 3'h3, 64, 0, 1, 1'b1);
    retry_case(0, 3'h3, 64, 0, 1, 1'b1);
    serr_on = 1'b1;
    for (int d = 0; d < 4; d++) begin
      mto_case(0, 1'b1, 2'(d), -1, 1'b0);
      mto_case(0, 1'b1, 2'(d), 0, 1'b1);
    end
    mto_case(1, 1'b1, 2'h3, -1, 1'b0);
    mto_case(1, 1'b1, 2'h3, 0, 1'b1);
    mto_case(1, 1'b0, 2'h2, 0, 1'b1);
    mto_case(1, 1'b0, 2'h3, -1, 1'b0);
    mto_case(1, 1'b0, 2'h3, 0, 1'b1);
    tally_and_finish();
  end

  // The whole sequence needs about 15000 cycles
  initial begin
    repeat (60000) @(posedge pclk);
    failures++;
    tally_and_finish();
  end
endmodule
